// [pkg/pwm_stage_pkg.sv]
package pwm_stage_pkg;

    // *****************************************
    // Register indices (byte address = 4 * index)
    // *****************************************
    localparam logic [6:0] IDX_STAGE_CTRL  = 7'h00; // Pair enables, pattern mode, soft blank
    localparam logic [6:0] IDX_THIRD_CTRL  = 7'h05; // Command field, write only
    localparam logic [6:0] IDX_FAULT_CTRL  = 7'h0a; // Fault action and restart mode
    localparam logic [6:0] IDX_STATE       = 7'h0f; // fault_and_blank_state
    localparam logic [6:0] IDX_DT_LOW      = 7'h10; // low_side_dead_time
    localparam logic [6:0] IDX_DT_HIGH     = 7'h11; // high_side_dead_time
    localparam logic [6:0] IDX_DT_BOTH     = 7'h12; // both_sides_dead_time
    localparam logic [6:0] IDX_PAIR_XCHG   = 7'h13; // pair_exchange
    localparam logic [6:0] IDX_PAT_OVR     = 7'h14; // pattern_override_enable
    localparam logic [6:0] IDX_PAT_VAL     = 7'h15; // pattern_output_value
    localparam logic [6:0] IDX_TAKEOVER    = 7'h17; // port_takeover_enable
    localparam logic [6:0] IDX_IRQ_STATUS  = 7'h20; // Sticky events, read only
    localparam logic [6:0] IDX_IRQ_CLEAR   = 7'h21; // Write one to clear
    localparam logic [6:0] IDX_IRQ_ENABLE  = 7'h22; // Interrupt enables

    // *****************************************
    // Field positions and codes
    // *****************************************
    localparam int         BIT_PGM         = 4;     // pattern_generation_mode in stage ctrl
    localparam int         BIT_SW_BLANK    = 5;     // Software blanking in stage ctrl
    localparam int         BIT_FSTATE      = 0;     // overall_fault_state
    localparam int         BIT_LIVE_A      = 2;     // fault_live_input_a, b and c follow
    localparam int         BIT_BLANK       = 7;     // blanking_active
    localparam logic [2:0] CMD_SW_FAULT    = 3'h1;  // Software-triggered fault
    localparam logic [2:0] CMD_FAULT_CLEAR = 3'h2;  // fault_clear_command
    localparam logic [1:0] ACT_NONE        = 2'h0;  // Protection disabled
    localparam logic [1:0] ACT_LOW         = 2'h1;  // Drive all taken-over pins low
    localparam logic [1:0] ACT_CUSTOM      = 2'h3;  // Custom drive, modelled as drive all taken-over pins low
    localparam logic [7:0] RESET_BYTE      = 8'h00; // Reset of every register
    localparam logic [1:0] RESP_OKAY       = 2'b00; // AXI okay
    localparam logic [1:0] RESP_SLVERR     = 2'b10; // AXI slave error

    // *****************************************
    // Carriers
    // *****************************************
    typedef struct packed {
        logic       debug_ignore;  // Debug break does not fault
        logic [3:0] unused;        // Reads zero
        logic       restart_mode;  // 1 = cycle_by_cycle_restart
        logic [1:0] action;        // fault_action
    } fault_ctrl_t;

    typedef struct packed {
        logic [2:0] event_flag;    // event_fault_flag C..A
        logic       fault_det;     // Rising edge of fault state
    } irq_bits_t;

endpackage

// [verilog/pwm_deadtime_override_stage.sv]
// How it works
// - Blanking state bit reads one while blanking
// - One live fault bit per event input
// - Any fault source sets overall fault state when fault action is not none
// - Clear command, or update in cycle-by-cycle mode, leaves fault state
// - Cycle-by-cycle mode clears at next update
// - Low side waits low dead-time cycles
// - High side waits high dead-time cycles
// - Combined write loads both dead times
// - Exchange bit swaps outputs of pair
// - Exchange ignores pair dead-time enables
// - Override bits replace exchanged output in pattern generation mode
// - Pattern value bit drives pin level
// - Takeover bits hand port bits to waveform
// - Takeover bits cannot clear under protection
// - Fault action none, low, reserved, custom
// - Latched restart also needs flags cleared
`timescale 1ns/1ps
`default_nettype none

module pwm_deadtime_override_stage #(
    parameter int PAIRS = 4,                     // Complementary pairs
    parameter int DT_W  = 8                      // Dead-time counter width
) (
    input  wire logic              aclk,         // 50 MHz clock
    input  wire logic              aresetn,      // Sync reset, active low
    input  wire logic [8:0]        s_axi_awaddr, // Write address
    input  wire logic              s_axi_awvalid, // Write address valid
    output logic                   s_axi_awready, // Write address ready
    input  wire logic [31:0]       s_axi_wdata,  // Write data
    input  wire logic [3:0]        s_axi_wstrb,  // Write strobes
    input  wire logic              s_axi_wvalid, // Write data valid
    output logic                   s_axi_wready, // Write data ready
    output logic [1:0]             s_axi_bresp,  // Write response
    output logic                   s_axi_bvalid, // Write response valid
    input  wire logic              s_axi_bready, // Write response ready
    input  wire logic [8:0]        s_axi_araddr, // Read address
    input  wire logic              s_axi_arvalid, // Read address valid
    output logic                   s_axi_arready, // Read address ready
    output logic [31:0]            s_axi_rdata,  // Read data
    output logic [1:0]             s_axi_rresp,  // Read response
    output logic                   s_axi_rvalid, // Read data valid
    input  wire logic              s_axi_rready, // Read data ready
    input  wire logic [2*PAIRS-1:0] wave_in,     // Timer waveforms, same clock
    input  wire logic              update_event, // Timer update pulse
    input  wire logic [2*PAIRS-1:0] port_out_reg, // Port output register
    input  wire logic [2:0]        fault_pin,    // Fault event inputs C..A, async
    input  wire logic              debug_break,  // Debug break request, async
    input  wire logic              blank_hw,     // Hardware blanking, async
    output logic [2*PAIRS-1:0]     pin_out,      // Pin levels to power stage
    output logic                   irq           // Level interrupt
);

    localparam int N = 2 * PAIRS;                // Output count

    // *****************************************
    // Synchronisers
    // *****************************************
    logic [4:0] sync_meta;                       // First stage, read by second only
    logic [4:0] sync_q;                          // Safe copies

    // Two flops on every asynchronous input
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_meta <= '0;
            sync_q    <= '0;
        end else begin
            sync_meta <= {blank_hw, debug_break, fault_pin};
            sync_q    <= sync_meta;
        end
    end

    // *****************************************
    // Register storage
    // *****************************************
    logic [7:0]         stage_ctrl;              // Pair enables, pgm, soft blank
    pwm_stage_pkg::fault_ctrl_t fault_ctrl;      // Fault control register
    logic [DT_W-1:0]    dt_low;                  // low_side_dead_time
    logic [DT_W-1:0]    dt_high;                 // high_side_dead_time
    logic [DT_W-1:0]    dt_both;                 // Last combined write
    logic [PAIRS-1:0]   pair_xchg;               // pair_exchange
    logic [N-1:0]       pat_ovr;                 // pattern_override_enable
    logic [N-1:0]       pat_val;                 // pattern_output_value
    logic [N-1:0]       takeover;                // port_takeover_enable
    pwm_stage_pkg::irq_bits_t irq_status;        // Sticky events
    pwm_stage_pkg::irq_bits_t irq_enable;        // Interrupt enables
    logic               fault_state;             // overall_fault_state

    // *****************************************
    // AXI4-Lite write channel
    // *****************************************
    logic [8:0]  aw_addr;                        // Held write address
    logic [31:0] w_data;                         // Held write data
    logic [3:0]  w_strb;                         // Held strobes
    logic        aw_full;                        // Address captured
    logic        w_full;                         // Data captured
    logic        wr_fire;                        // Write performed this cycle
    logic [6:0]  wr_idx;                         // Word index written
    logic [7:0]  wr_byte;                        // Low data byte
    logic        wr_lane;                        // Low byte lane enabled

    assign wr_fire = aw_full && w_full && !s_axi_bvalid;
    assign wr_idx  = aw_addr[8:2];
    assign wr_byte = w_data[7:0];
    assign wr_lane = wr_fire && w_strb[0];

    // Address and data taken in either order, held till both present
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full       <= 1'b0;
            w_full        <= 1'b0;
            aw_addr       <= '0;
            w_data        <= '0;
            w_strb        <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !aw_full && !s_axi_awready;
            s_axi_wready  <= !w_full && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_full <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_full <= 1'b0;
            end
        end
    end

    // Write decode: which index is mapped
    function automatic logic mapped(input logic [6:0] idx);
        case (idx)
            pwm_stage_pkg::IDX_STAGE_CTRL, pwm_stage_pkg::IDX_THIRD_CTRL,
            pwm_stage_pkg::IDX_FAULT_CTRL, pwm_stage_pkg::IDX_STATE,
            pwm_stage_pkg::IDX_DT_LOW,     pwm_stage_pkg::IDX_DT_HIGH,
            pwm_stage_pkg::IDX_DT_BOTH,    pwm_stage_pkg::IDX_PAIR_XCHG,
            pwm_stage_pkg::IDX_PAT_OVR,    pwm_stage_pkg::IDX_PAT_VAL,
            pwm_stage_pkg::IDX_TAKEOVER,   pwm_stage_pkg::IDX_IRQ_STATUS,
            pwm_stage_pkg::IDX_IRQ_CLEAR,  pwm_stage_pkg::IDX_IRQ_ENABLE: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction

    // Write response one cycle after both halves meet
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= pwm_stage_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(wr_idx) ? pwm_stage_pkg::RESP_OKAY : pwm_stage_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // *****************************************
    // Configuration registers
    // *****************************************
    logic protect_on;                            // Fault action is not none
    assign protect_on = fault_ctrl.action != pwm_stage_pkg::ACT_NONE;

    // Plain software registers; both dead times share one write port
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage_ctrl <= pwm_stage_pkg::RESET_BYTE;
            fault_ctrl <= pwm_stage_pkg::RESET_BYTE;
            dt_low     <= pwm_stage_pkg::RESET_BYTE;
            dt_high    <= pwm_stage_pkg::RESET_BYTE;
            dt_both    <= pwm_stage_pkg::RESET_BYTE;
            pair_xchg  <= '0;
            pat_ovr    <= pwm_stage_pkg::RESET_BYTE;
            pat_val    <= pwm_stage_pkg::RESET_BYTE;
            takeover   <= pwm_stage_pkg::RESET_BYTE;
            irq_enable <= '0;
        end else if (wr_lane) begin
            unique case (wr_idx)
                pwm_stage_pkg::IDX_STAGE_CTRL: stage_ctrl <= wr_byte;
                pwm_stage_pkg::IDX_FAULT_CTRL: begin
                    fault_ctrl        <= wr_byte;
                    fault_ctrl.unused <= '0;
                end
                pwm_stage_pkg::IDX_DT_LOW:  dt_low  <= wr_byte;
                pwm_stage_pkg::IDX_DT_HIGH: dt_high <= wr_byte;
                pwm_stage_pkg::IDX_DT_BOTH: begin
                    dt_both <= wr_byte;
                    dt_low  <= wr_byte;
                    dt_high <= wr_byte;
                end
                pwm_stage_pkg::IDX_PAIR_XCHG:  pair_xchg <= wr_byte[PAIRS-1:0];
                pwm_stage_pkg::IDX_PAT_OVR:    pat_ovr   <= wr_byte;
                pwm_stage_pkg::IDX_PAT_VAL:    pat_val   <= wr_byte;
                // Under protection a write may only add bits
                pwm_stage_pkg::IDX_TAKEOVER:   takeover  <= protect_on ? (takeover | wr_byte) : wr_byte;
                pwm_stage_pkg::IDX_IRQ_ENABLE: irq_enable <= {wr_byte[4:2], wr_byte[0]}; // Status layout
                default: ;
            endcase
        end
    end

    // *****************************************
    // Fault detection
    // *****************************************
    logic       blanking;                        // blanking_active
    logic [2:0] live;                            // Live fault per event input
    logic       cmd_wr;                          // Command field written
    logic       sw_fault;                        // Software fault command
    logic       clr_cmd;                         // fault_clear_command seen
    logic       dbg_fault;                       // Debug break counts as fault
    logic       any_source;                      // Some fault source present
    logic       fault_prev;                      // For edge detection
    logic [3:0] irq_clear;                       // W1C strobes

    assign blanking   = sync_q[4] || stage_ctrl[pwm_stage_pkg::BIT_SW_BLANK];
    // Blanking hides event inputs, the usual reason to blank
    assign live       = blanking ? 3'b000 : sync_q[2:0];
    assign cmd_wr     = wr_lane && wr_idx == pwm_stage_pkg::IDX_THIRD_CTRL;
    assign sw_fault   = cmd_wr && wr_byte[2:0] == pwm_stage_pkg::CMD_SW_FAULT;
    assign clr_cmd    = cmd_wr && wr_byte[2:0] == pwm_stage_pkg::CMD_FAULT_CLEAR;
    assign dbg_fault  = sync_q[3] && !fault_ctrl.debug_ignore;
    assign any_source = protect_on && (|live || sw_fault || dbg_fault);
    assign irq_clear  = (wr_lane && wr_idx == pwm_stage_pkg::IDX_IRQ_CLEAR) ? {wr_byte[4:2], wr_byte[0]} : 4'h0;

    // Overall state: a new source wins over any clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_state <= 1'b0;
        end else if (any_source) begin
            fault_state <= 1'b1;
        end else if (fault_ctrl.restart_mode) begin
            if (clr_cmd || update_event) begin
                fault_state <= 1'b0;
            end
        end else if (clr_cmd && irq_status.event_flag == 3'b000) begin
            fault_state <= 1'b0;
        end
    end

    // Sticky event flags and interrupt: set beats clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= '0;
            fault_prev <= 1'b0;
            irq        <= 1'b0;
        end else begin
            fault_prev           <= fault_state;
            irq_status.event_flag <= (protect_on ? live : 3'b000) | (irq_status.event_flag & ~irq_clear[3:1]);
            irq_status.fault_det <= (fault_state && !fault_prev) || (irq_status.fault_det && !irq_clear[0]);
            irq                  <= |(irq_status & irq_enable);
        end
    end

    // *****************************************
    // Dead-time units
    // *****************************************
    logic [N-1:0]    dti_out;                    // Unit outputs, low at 2n
    logic [DT_W-1:0] cnt [N];                    // Per-side wait counters
    logic [N-1:0]    want;                       // Requested side levels

    // Each pair turns one waveform into a low and a high side
    always_comb begin
        for (int p = 0; p < PAIRS; p++) begin
            want[2*p]   = !wave_in[2*p];
            want[2*p+1] = wave_in[2*p];
        end
    end

    // In an enabled pair a side rises only after its partner is low and its wait is over
    // Rise lands D cycles after the partner fell, but never sooner than one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dti_out <= '0;
            for (int i = 0; i < N; i++) begin
                cnt[i] <= '0;
            end
        end else begin
            for (int i = 0; i < N; i++) begin
                if (!stage_ctrl[i/2]) begin
                    dti_out[i] <= wave_in[i];             // Pair bypassed
                    cnt[i]     <= '0;
                end else if (!want[i] || dti_out[i^1]) begin
                    dti_out[i] <= 1'b0;
                    cnt[i]     <= '0;
                end else if (cnt[i] + 1'b1 >= ((i % 2 == 0) ? dt_low : dt_high)) begin
                    dti_out[i] <= 1'b1;
                end else begin
                    cnt[i]     <= cnt[i] + 1'b1;
                end
            end
        end
    end

    // *****************************************
    // Exchange, pattern, fault and port stage
    // *****************************************
    logic [N-1:0] xchg;                          // After pair exchange
    logic [N-1:0] patt;                          // After pattern override
    logic [N-1:0] next_pin;                      // Pin value to register

    // Exchange works on unit outputs whatever the pair enables say
    always_comb begin
        for (int p = 0; p < PAIRS; p++) begin
            xchg[2*p]   = pair_xchg[p] ? dti_out[2*p+1] : dti_out[2*p];
            xchg[2*p+1] = pair_xchg[p] ? dti_out[2*p] : dti_out[2*p+1];
        end
    end

    // Override only acts in pattern generation mode
    assign patt = stage_ctrl[pwm_stage_pkg::BIT_PGM] ? ((xchg & ~pat_ovr) | (pat_val & pat_ovr)) : xchg;

    // Fault drives low under action low; custom drive is not modelled here and also drives low
    always_comb begin
        next_pin = patt;
        unique case (fault_ctrl.action)
            pwm_stage_pkg::ACT_LOW, pwm_stage_pkg::ACT_CUSTOM: begin
                if (fault_state) begin
                    next_pin = '0;
                end
            end
            default: ;
        endcase
        next_pin = (next_pin & takeover) | (port_out_reg & ~takeover);
    end

    // Registered pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out <= '0;
        end else begin
            pin_out <= next_pin;
        end
    end

    // *****************************************
    // AXI4-Lite read channel
    // *****************************************
    logic [7:0] rd_byte;                         // Selected register
    logic [6:0] rd_idx;                          // Read index
    assign rd_idx = s_axi_araddr[8:2];

    // Read mux; reserved bits and write-only words read zero
    always_comb begin
        rd_byte = '0;
        unique case (rd_idx)
            pwm_stage_pkg::IDX_STAGE_CTRL: rd_byte = stage_ctrl;
            pwm_stage_pkg::IDX_FAULT_CTRL: rd_byte = fault_ctrl;
            pwm_stage_pkg::IDX_STATE: begin
                rd_byte[pwm_stage_pkg::BIT_BLANK]  = blanking;
                rd_byte[pwm_stage_pkg::BIT_LIVE_A +: 3] = live;
                rd_byte[pwm_stage_pkg::BIT_FSTATE] = fault_state;
            end
            pwm_stage_pkg::IDX_DT_LOW:     rd_byte = dt_low;
            pwm_stage_pkg::IDX_DT_HIGH:    rd_byte = dt_high;
            pwm_stage_pkg::IDX_DT_BOTH:    rd_byte = dt_both;
            pwm_stage_pkg::IDX_PAIR_XCHG:  rd_byte[PAIRS-1:0] = pair_xchg;
            pwm_stage_pkg::IDX_PAT_OVR:    rd_byte = pat_ovr;
            pwm_stage_pkg::IDX_PAT_VAL:    rd_byte = pat_val;
            pwm_stage_pkg::IDX_TAKEOVER:   rd_byte = takeover;
            pwm_stage_pkg::IDX_IRQ_STATUS: rd_byte[4:0] = {irq_status.event_flag, 1'b0, irq_status.fault_det};
            pwm_stage_pkg::IDX_IRQ_ENABLE: rd_byte[4:0] = {irq_enable.event_flag, 1'b0, irq_enable.fault_det};
            default: rd_byte = '0;
        endcase
    end

    // Address taken when idle; data one cycle later
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= pwm_stage_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h00_0000, rd_byte};
                s_axi_rresp  <= mapped(rd_idx) ? pwm_stage_pkg::RESP_OKAY : pwm_stage_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// [dv/pwm_stage_sva.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************
// Bus and pin checks
// ****************
module pwm_stage_sva #(parameter int PAIRS = 4) (
    input wire logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, // Clock, reset, write
    input wire logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, // Handshakes
    input wire logic s_axi_arready, s_axi_rvalid, s_axi_rready, irq, // Read side, interrupt
    input wire logic [8:0] s_axi_araddr, // Read address
    input wire logic [31:0] s_axi_rdata, // Read data
    input wire logic [1:0] s_axi_rresp, // Read response
    input wire logic [2*PAIRS-1:0] pin_out // Pins
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Both halves of a write taken together
    sequence s_wr_taken; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid) else $error("no write response");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read data");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_wresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
    a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[8:2] == 7'h16 |=>
        s_axi_rresp == pwm_stage_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000) else $error("hole not refused");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000) else $error("upper bits set");
    a_reset_quiet: assert property ($rose(aresetn) |-> pin_out == '0 && !irq && !s_axi_rvalid && !s_axi_bvalid)
        else $error("outputs not cleared by reset");
endmodule
bind pwm_deadtime_override_stage pwm_stage_sva #(.PAIRS(PAIRS)) pwm_stage_sva_i (.*);
`default_nettype wire

// [dv/power_stage_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Power stage: reports overcurrent on fault line A after LAG cycles
module power_stage_model #(parameter int LAG = 3) (
    input wire logic aclk, // Clock
    input wire logic trip, // Overcurrent request from bench
    output logic [2:0] fault_pin // Fault lines C..A
);
    logic [LAG-1:0] dly = '0; // Slow sensor delay line
    always_ff @(posedge aclk) begin
        dly <= {dly[LAG-2:0], trip};
    end
    assign fault_pin = {2'b00, dly[LAG-1]};
endmodule
`default_nettype wire

// [dv/pwm_deadtime_override_stage_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module pwm_deadtime_override_stage_bench;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, update_event = 0, debug_break = 0, blank_hw = 0, trip = 0, prot = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [8:0] s_axi_awaddr = 9'h000, s_axi_araddr = 9'h000;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [7:0] wave_in = 8'h00, port_out_reg = 8'h00, pin_out, pv, m [int]; // m: register model
    logic [2:0] fault_pin;
    int fail_count = 0, n_tests = 0;
    always #10 aclk = ~aclk;
    pwm_deadtime_override_stage pwm_deadtime_override_stage_i (.*);
    power_stage_model #(.LAG(3)) power_stage_model_i (.aclk(aclk), .trip(trip), .fault_pin(fault_pin));
    // ****************
    // Bus tasks and compare
    // ****************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin fail_count++; $display("MISMATCH %s exp %h got %h", nm, e, g); end
    endtask
    task automatic wr(input logic [6:0] ix, input logic [7:0] v);
        bit a = 0, w = 0;
        @(posedge aclk); s_axi_awaddr <= {ix, 2'b00}; s_axi_wdata <= {24'h00_0000, v};
        s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
        while (!(a && w)) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin a = 1; s_axi_awvalid <= 0; end
            if (s_axi_wvalid && s_axi_wready) begin w = 1; s_axi_wvalid <= 0; end
        end
        while (!s_axi_bvalid) @(posedge aclk);
        chk("bresp", 2'b00, s_axi_bresp);
        s_axi_bready <= 0;
        if (ix == 7'h12) begin m[16] = v; m[17] = v; end
        if (m.exists(ix)) m[ix] = (ix == 7'h17 && prot) ? m[ix] | v : (ix == 7'h13 ? v & 8'h0f : v);
    endtask
    task automatic rd(input logic [6:0] ix);
        @(posedge aclk); s_axi_araddr <= {ix, 2'b00}; s_axi_arvalid <= 1; s_axi_rready <= 1;
        do begin @(posedge aclk); if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0; end while (!s_axi_rvalid);
        d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 0;
    endtask
    task automatic rc(input logic [6:0] ix, input logic [7:0] e);
        rd(ix); chk("register", {24'h00_0000, e}, d);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Watchdog cuts a hang short
    initial begin repeat (20000) @(posedge aclk); fail_count++; summarize; end
    initial begin
        void'($urandom(84));
        for (int i = 16; i < 24; i++) if (i != 22) m[i] = 8'h00;
        repeat (3) @(posedge aclk); aresetn <= 1;
        foreach (m[i]) rc(7'(i), m[i]);
        foreach (m[i]) wr(7'(i), 8'($urandom));
        foreach (m[i]) rc(7'(i), m[i]);
        rd(7'h16); chk("resp", 2'b10, r);
        wr(7'h17, 8'hff); wr(7'h00, 8'h10); wr(7'h14, 8'hff); pv = $urandom; wr(7'h15, pv);
        repeat (4) @(posedge aclk); chk("pattern", pv, pin_out);
        wr(7'h14, 8'h00); wr(7'h00, 8'h00); wr(7'h13, 8'h0f); pv = $urandom; wave_in <= pv;
        repeat (4) @(posedge aclk); chk("swap", ((pv & 8'h55) << 1) | ((pv >> 1) & 8'h55), pin_out);
        port_out_reg <= $urandom; wr(7'h17, 8'h00);
        repeat (4) @(posedge aclk); chk("port", port_out_reg, pin_out);
        wr(7'h17, 8'hff); wr(7'h22, 8'h01); wr(7'h0a, 8'h01); prot = 1; wr(7'h17, 8'h00); rc(7'h17, m[23]);
        trip <= 1; repeat (8) @(posedge aclk); rc(7'h0f, 8'h05);
        chk("pins", 0, pin_out); chk("irq", 1, irq);
        trip <= 0; repeat (8) @(posedge aclk); wr(7'h05, 8'h02); rc(7'h0f, 8'h01);
        wr(7'h21, 8'h1d); wr(7'h05, 8'h02); rc(7'h0f, 8'h00); chk("irq", 0, irq);
        wr(7'h0a, 8'h05); trip <= 1; repeat (8) @(posedge aclk); trip <= 0;
        repeat (8) @(posedge aclk); rc(7'h0f, 8'h01); update_event <= 1; @(posedge aclk); update_event <= 0;
        repeat (2) @(posedge aclk); rc(7'h0f, 8'h00);
        blank_hw <= 1; repeat (4) @(posedge aclk); rc(7'h0f, 8'h80);
        // Pair 0: low wait 2, high wait 5; pin seen D+3 edges after the waveform turns
        wr(7'h13, 8'h00); wr(7'h10, 8'h02); wr(7'h11, 8'h05); wr(7'h00, 8'h01); wave_in <= 8'h00;
        for (int s = 1; s >= 0; s--) begin
            repeat (12) @(posedge aclk); wave_in <= 8'(s); pv = 8'h00;
            while (!pin_out[s]) begin @(posedge aclk); pv++; chk("overlap", 0, &pin_out[1:0]); end
            chk("dead time", s ? 8 : 5, pv);
        end
        summarize;
    end
endmodule
`default_nettype wire
